// ### mdr_cfg.svh
`ifndef MDR_CFG_SVH
`define MDR_CFG_SVH

// ----------------------------------------------------------------
// address map
// ----------------------------------------------------------------
`define MDR_WIN_TOP 16'h03ff
`define MDR_WIN_AW 10
`define MDR_PAD_AW 8
`define MDR_SFR_BASE 8'h80

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define MDR_CLK_NS 4
`define MDR_MC_CLKS 6'h04
`define MDR_ALE_END 6'h01
`define MDR_STRETCH_MIN 4'h2
`define MDR_STRETCH_MAX 4'h9

`endif

// ### mdr_ext_mem.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// external byte memory on the multiplexed bus
// ----------------------------------------------------------------
module mdr_ext_mem (
    input wire logic ref_clk,
    input wire logic ale,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic psen_n,
    input wire logic [7:0] p0_out,
    input wire logic [7:0] p2_out,
    input wire logic [7:0] wait_hold,
    output logic [7:0] p0_drv,
    output logic wait_n
);
    logic [7:0] mem [0:65535]; // whole 64 KB data space
    logic [15:0] addr = 16'h0000; // address caught during the address phase
    logic [7:0] last = 8'h00; // last byte put on the data lines
    logic idle_q = 1'b1; // read and write strobes idle one clock ago
    logic [7:0] hold = 8'h00; // wait clocks still to insert
    logic reading; // a read or fetch strobe is low

    assign reading = !(rd_n && psen_n);
    // released lines show the inverse of the last byte, no pull-ups here
    assign p0_drv = reading ? mem[addr] : ~last;
    assign wait_n = (hold == 8'h00);

    // latch, store, and start a wait hold when a read or write strobe falls
    always @(posedge ref_clk) begin
        if (ale) begin
            addr <= {p2_out, p0_out};
        end
        if (!wr_n) begin
            mem[addr] <= p0_out;
        end
        if (reading) begin
            last <= mem[addr];
        end
        idle_q <= rd_n && wr_n;
        if (idle_q && !(rd_n && wr_n)) begin
            hold <= wait_hold;
        end else if (hold != 8'h00) begin
            hold <= hold - 8'h01;
        end
    end
endmodule : mdr_ext_mem

// ### mdr_mem.sv
`timescale 1ns/100ps
// single-port byte memory with registered read data
module mdr_mem #(
    parameter int AW = 10
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic en,
    input wire logic we,
    input wire logic [AW-1:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);
    // storage, no reset: contents are undefined after power-up
    logic [7:0] mem [0:(1<<AW)-1];
    logic [7:0] next_rdata;

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    always_comb begin
        next_rdata = rdata;
        if (en && !we) begin
            next_rdata = mem[addr];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            rdata <= 8'h00;
        end else begin
            rdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // write path
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (en && we) begin
            mem[addr] <= wdata;
        end
    end

endmodule : mdr_mem

// ### mdr_pkg.sv
package mdr_pkg;

    // access kinds seen from the core
    typedef enum logic [1:0] {
        MDR_KIND_MOVE = 2'h0,
        MDR_KIND_DIRECT = 2'h1,
        MDR_KIND_INDIRECT = 2'h2,
        MDR_KIND_FETCH = 2'h3
    } mdr_kind_t;

    // sequencer states, one-hot
    typedef enum logic [3:0] {
        MDR_IDLE = 4'h1,
        MDR_INT = 4'h2,
        MDR_ADDR = 4'h4,
        MDR_STRB = 4'h8
    } mdr_state_t;

    // request from the core
    typedef struct packed {
        logic valid;
        logic write;
        mdr_kind_t kind;
        logic [15:0] addr;
        logic [7:0] wdata;
    } mdr_req_t;

    // answer to the core
    typedef struct packed {
        logic done;
        logic sfr_hit;
        logic [7:0] rdata;
    } mdr_rsp_t;

endpackage : mdr_pkg

// ### mdr_router.sv
`timescale 1ns/100ps
`include "mdr_cfg.svh"
// routes data moves to the on-chip window, the scratchpad or the external bus
module mdr_router
    import mdr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input mdr_req_t req,
    output logic busy,
    output mdr_rsp_t rsp,
    input wire logic sram_en_wr,
    input wire logic sram_en_val,
    output logic onchip_sram_enable,
    input wire logic [3:0] stretch,
    input wire logic wait_enable,
    input wire logic wait_gpio_out,
    input wire logic wait_gpio_oe,
    input wire logic wait_capable_pin_in,
    output logic wait_capable_pin_out,
    output logic wait_capable_pin_oe,
    input wire logic [7:0] p0_in,
    output logic [7:0] p0_out,
    output logic [7:0] p0_oe,
    output logic [7:0] p2_out,
    output logic [7:0] p2_oe,
    output logic ale,
    output logic rd_n,
    output logic wr_n,
    output logic psen_n
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    mdr_state_t state, next_state; // sequencer
    logic [5:0] cnt, next_cnt; // clocks left in current phase
    logic [3:0] stretch_q, next_stretch_q; // latched move length
    mdr_req_t cur, next_cur; // request in flight
    logic next_busy;
    mdr_rsp_t next_rsp;
    logic next_sram_en;
    logic [7:0] next_p0_out, next_p0_oe, next_p2_out, next_p2_oe;
    logic next_ale, next_rd_n, next_wr_n, next_psen_n;
    logic next_wait_out, next_wait_oe;
    // pin synchronisers, first stage read only by the second
    logic [7:0] p0_s1, p0_s2;
    logic wait_s1, wait_s2;
    // memory hookup
    logic win_en, pad_en;
    logic [7:0] win_rdata, pad_rdata;
    logic to_win, to_pad, is_sfr, in_window;
    logic [3:0] stretch_cl;
    logic wait_hold;

    // ------------------------------------------------------------
    // routing decode
    // ------------------------------------------------------------
    always_comb begin
        in_window = req.addr <= `MDR_WIN_TOP;
        // window only for data moves, never for fetches
        to_win = req.valid && (req.kind == MDR_KIND_MOVE)
            && onchip_sram_enable && in_window;
        // registers answer only to direct addressing at 80h and up
        is_sfr = (req.kind == MDR_KIND_DIRECT)
            && (req.addr[7:0] >= `MDR_SFR_BASE);
        to_pad = req.valid && !is_sfr && ((req.kind == MDR_KIND_DIRECT)
            || (req.kind == MDR_KIND_INDIRECT));
        // clamp move length to the legal range
        if (stretch < `MDR_STRETCH_MIN) begin
            stretch_cl = `MDR_STRETCH_MIN;
        end else if (stretch > `MDR_STRETCH_MAX) begin
            stretch_cl = `MDR_STRETCH_MAX;
        end else begin
            stretch_cl = stretch;
        end
        win_en = (state == MDR_IDLE) && to_win;
        pad_en = (state == MDR_IDLE) && to_pad;
        // wait pin is active low; ignored unless enabled
        wait_hold = wait_enable && !wait_s2;
    end

    // on-chip window, 1 KB
    mdr_mem #(.AW(`MDR_WIN_AW)) u_win (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .en(win_en),
        .we(req.write),
        .addr(req.addr[`MDR_WIN_AW-1:0]),
        .wdata(req.wdata),
        .rdata(win_rdata)
    );

    // scratchpad, 256 bytes, its own address space
    mdr_mem #(.AW(`MDR_PAD_AW)) u_pad (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .en(pad_en),
        .we(req.write),
        .addr(req.addr[`MDR_PAD_AW-1:0]),
        .wdata(req.wdata),
        .rdata(pad_rdata)
    );

    // ------------------------------------------------------------
    // sequencer and pins
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_stretch_q = stretch_q;
        next_cur = cur;
        next_rsp = '0;
        next_sram_en = onchip_sram_enable;
        next_p0_out = p0_out;
        next_p0_oe = p0_oe;
        next_p2_out = p2_out;
        next_p2_oe = p2_oe;
        next_ale = 1'b0;
        next_rd_n = 1'b1;
        next_wr_n = 1'b1;
        next_psen_n = 1'b1;
        if (sram_en_wr) begin
            next_sram_en = sram_en_val;
        end
        // wait pin turns input-only while the wait function is on
        next_wait_out = wait_gpio_out;
        next_wait_oe = wait_gpio_oe && !wait_enable;
        unique case (state)
            MDR_IDLE: begin
                // bus released: low port back to open-drain port logic
                next_p0_oe = 8'h00;
                next_p2_oe = 8'h00;
                if (req.valid) begin
                    next_cur = req;
                    if (to_win || to_pad) begin
                        next_state = MDR_INT;
                    end else if (is_sfr) begin
                        next_rsp.done = 1'b1;
                        next_rsp.sfr_hit = 1'b1;
                    end else begin
                        // address phase: one machine cycle
                        next_state = MDR_ADDR;
                        next_cnt = `MDR_MC_CLKS - 6'h01;
                        next_stretch_q = (req.kind == MDR_KIND_FETCH)
                            ? `MDR_STRETCH_MIN : stretch_cl;
                        next_ale = 1'b1;
                        next_p0_out = req.addr[7:0];
                        next_p0_oe = 8'hff;
                        next_p2_out = req.addr[15:8];
                        next_p2_oe = 8'hff;
                    end
                end
            end
            MDR_INT: begin
                // one-cycle internal access, pins untouched
                next_state = MDR_IDLE;
                next_rsp.done = 1'b1;
                next_rsp.rdata = (cur.kind == MDR_KIND_MOVE) ? win_rdata : pad_rdata;
            end
            MDR_ADDR: begin
                next_ale = (cnt > `MDR_ALE_END); // latch strobe in the early clocks
                if (cnt == 6'h00) begin
                    next_state = MDR_STRB;
                    // strobe phase fills the rest of the move
                    next_cnt = 6'({2'h0, stretch_q} * `MDR_MC_CLKS)
                        - `MDR_MC_CLKS - 6'h01;
                    next_p0_oe = cur.write ? 8'hff : 8'h00;
                    next_p0_out = cur.wdata;
                    next_wr_n = !(cur.write && cur.kind == MDR_KIND_MOVE);
                    next_rd_n = !(!cur.write && cur.kind == MDR_KIND_MOVE);
                    next_psen_n = !(cur.kind == MDR_KIND_FETCH);
                end else begin
                    next_cnt = cnt - 6'h01;
                end
            end
            MDR_STRB: begin
                next_wr_n = wr_n;
                next_rd_n = rd_n;
                next_psen_n = psen_n;
                if (cnt != 6'h00) begin
                    next_cnt = cnt - 6'h01;
                end else if (!wait_hold) begin
                    // end of move: strobes rise, read data captured
                    next_state = MDR_IDLE;
                    next_wr_n = 1'b1;
                    next_rd_n = 1'b1;
                    next_psen_n = 1'b1;
                    next_rsp.done = 1'b1;
                    next_rsp.rdata = p0_s2;
                end
            end
            default: begin
                next_state = MDR_IDLE;
            end
        endcase
        next_busy = (next_state != MDR_IDLE);
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            state <= MDR_IDLE;
            cnt <= 6'h00;
            stretch_q <= `MDR_STRETCH_MIN;
            cur <= '0;
            busy <= 1'b0;
            rsp <= '0;
            onchip_sram_enable <= 1'b0;
            p0_out <= 8'h00;
            p0_oe <= 8'h00;
            p2_out <= 8'h00;
            p2_oe <= 8'h00;
            ale <= 1'b0;
            rd_n <= 1'b1;
            wr_n <= 1'b1;
            psen_n <= 1'b1;
            wait_capable_pin_out <= 1'b1;
            wait_capable_pin_oe <= 1'b0;
            p0_s1 <= 8'h00;
            p0_s2 <= 8'h00;
            wait_s1 <= 1'b1;
            wait_s2 <= 1'b1;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            stretch_q <= next_stretch_q;
            cur <= next_cur;
            busy <= next_busy;
            rsp <= next_rsp;
            onchip_sram_enable <= next_sram_en;
            p0_out <= next_p0_out;
            p0_oe <= next_p0_oe;
            p2_out <= next_p2_out;
            p2_oe <= next_p2_oe;
            ale <= next_ale;
            rd_n <= next_rd_n;
            wr_n <= next_wr_n;
            psen_n <= next_psen_n;
            wait_capable_pin_out <= next_wait_out;
            wait_capable_pin_oe <= next_wait_oe;
            p0_s1 <= p0_in;
            p0_s2 <= p0_s1;
            wait_s1 <= wait_capable_pin_in;
            wait_s2 <= wait_s1;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    // helper: clocks spent in the strobe phase, and any wait seen
    logic [6:0] strb_len;
    logic waited;
    always_ff @(posedge ref_clk) begin
        if (!nrst || state != MDR_STRB) begin
            strb_len <= 7'h00;
            waited <= 1'b0;
        end else begin
            strb_len <= strb_len + 7'h01;
            waited <= waited | wait_hold;
        end
    end

    a_reset_clears_en: assert property (
        $rose(nrst) |-> !onchip_sram_enable) else $error("enable set after reset");
    a_window_low_int: assert property (
        state == MDR_IDLE && req.valid && req.kind == MDR_KIND_MOVE
        && onchip_sram_enable && req.addr <= `MDR_WIN_TOP && !sram_en_wr
        |=> state == MDR_INT ##1 rsp.done) else $error("window move not internal");
    a_fetch_never_int: assert property (
        state == MDR_IDLE && req.valid && req.kind == MDR_KIND_FETCH
        |=> state == MDR_ADDR) else $error("fetch served on chip");
    a_disabled_ext: assert property (
        state == MDR_IDLE && req.valid && req.kind == MDR_KIND_MOVE && !onchip_sram_enable
        |=> state == MDR_ADDR && ale) else $error("move not external");
    a_high_addr_ext: assert property (
        state == MDR_IDLE && req.valid && req.kind == MDR_KIND_MOVE
        && req.addr > `MDR_WIN_TOP |=> p2_out == $past(req.addr[15:8]) && p2_oe == 8'hff)
        else $error("upper address not driven");
    a_sfr_direct_only: assert property (
        rsp.sfr_hit |-> $past(req.kind) == MDR_KIND_DIRECT) else $error("register hit");
    a_int_quiet_pins: assert property (
        state == MDR_INT |-> rd_n && wr_n && !ale && p0_oe == 8'h00)
        else $error("pins moved on internal access");
    a_ale_cycle: assert property (
        $rose(ale) |-> ale[*3] ##1 !ale) else $error("address phase length wrong");
    a_write_drive: assert property (
        !wr_n |-> p0_oe == 8'hff && p2_oe == 8'hff && rd_n) else $error("write bus not driven");
    a_move_len: assert property (
        state == MDR_STRB && cnt == 6'h00 && !wait_hold && !waited
        |-> strb_len == 7'({3'h0, stretch_q} * `MDR_MC_CLKS - `MDR_MC_CLKS - 6'h01))
        else $error("move length wrong");
    a_wait_input: assert property (
        wait_enable |=> !wait_capable_pin_oe) else $error("wait pin driven");
    a_read_strobe: assert property (
        state == MDR_ADDR && cnt == 6'h00 && !cur.write && cur.kind == MDR_KIND_MOVE
        |=> !rd_n && wr_n) else $error("read strobe missing");

    c_int_move: cover property (state == MDR_INT && cur.kind == MDR_KIND_MOVE);
    c_ext_write: cover property ($fell(wr_n));
    c_ext_wait: cover property (state == MDR_STRB && wait_hold);
    c_long_move: cover property (state == MDR_ADDR && stretch_q == `MDR_STRETCH_MAX);

endmodule : mdr_router

// ### mdr_router_test.sv
`timescale 1ns/100ps
`define CHK(what, exp, got) begin n_compared++; if ((got) !== (exp)) begin err_count++; \
    $display("ERROR %s expected %0h seen %0h", what, exp, got); end end
module mdr_router_test
    import mdr_pkg::*;
;
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    mdr_req_t req = '0;
    logic busy;
    mdr_rsp_t rsp;
    logic sram_en_wr = 1'b0;
    logic sram_en_val = 1'b0;
    logic onchip_sram_enable;
    logic [3:0] stretch = 4'h2;
    logic wait_enable = 1'b0;
    logic wait_gpio_out = 1'b1;
    logic wait_gpio_oe = 1'b0;
    logic pin_in, pin_out, pin_oe, ext_wait_n;
    logic [7:0] p0_in, p0_out, p0_oe, p2_out, p2_oe, ext_drv;
    logic [7:0] wait_hold = 8'h00;
    logic ale, rd_n, wr_n, psen_n;
    int err_count = 0;
    int n_compared = 0;
    int cyc, n_ale, n_rd, n_wr, n_ps, n_bad; // what the last access looked like
    logic [15:0] seen_a;
    logic [7:0] got;
    logic hit;

    always #2 ref_clk = ~ref_clk; // 250 MHz
    // wire levels: whoever enables drives, otherwise the external memory drives p0 and the wait pin
    assign p0_in = (p0_oe & p0_out) | (~p0_oe & ext_drv);
    assign pin_in = pin_oe ? pin_out : ext_wait_n;

    mdr_router DUT (.ref_clk(ref_clk), .nrst(nrst), .req(req), .busy(busy), .rsp(rsp),
        .sram_en_wr(sram_en_wr), .sram_en_val(sram_en_val),
        .onchip_sram_enable(onchip_sram_enable), .stretch(stretch),
        .wait_enable(wait_enable), .wait_gpio_out(wait_gpio_out),
        .wait_gpio_oe(wait_gpio_oe), .wait_capable_pin_in(pin_in),
        .wait_capable_pin_out(pin_out), .wait_capable_pin_oe(pin_oe), .p0_in(p0_in),
        .p0_out(p0_out), .p0_oe(p0_oe), .p2_out(p2_out), .p2_oe(p2_oe), .ale(ale),
        .rd_n(rd_n), .wr_n(wr_n), .psen_n(psen_n));
    mdr_ext_mem u_ext (.ref_clk(ref_clk), .ale(ale), .rd_n(rd_n), .wr_n(wr_n),
        .psen_n(psen_n), .p0_out(p0_out), .p2_out(p2_out), .wait_hold(wait_hold),
        .p0_drv(ext_drv), .wait_n(ext_wait_n));

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task end_of_test;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_of_test

    // byte pattern stored externally for an address
    function automatic logic [7:0] pat(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5a;
    endfunction : pat

    // one access: request held until the taking edge, then watched until done
    task access(input mdr_kind_t k, input logic w, input logic [15:0] a, input logic [7:0] d);
        int i;
        cyc = 0; n_ale = 0; n_rd = 0; n_wr = 0; n_ps = 0; n_bad = 0;
        req = '{1'b1, w, k, a, d};
        for (i = 1; i <= 400; i++) begin
            @(posedge ref_clk);
            #1;
            if (i == 1) req.valid = 1'b0;
            if (ale !== 1'b0) begin
                n_ale++;
                seen_a = {p2_out, p0_out};
                if (p0_oe !== 8'hff || p2_oe !== 8'hff) n_bad++;
            end
            if (rd_n !== 1'b1) n_rd++;
            if (rd_n !== 1'b1 && p0_oe !== 8'h00) n_bad++; // no fight on read data
            if (wr_n !== 1'b1) n_wr++;
            if (psen_n !== 1'b1) n_ps++;
            if (rsp.done === 1'b1) begin
                cyc = i;
                got = rsp.rdata;
                hit = rsp.sfr_hit;
                break;
            end
        end
        if (cyc == 0) begin
            err_count++;
            $display("ERROR access done expected 1 seen 0");
            end_of_test();
        end
    endtask : access

    // one-cycle write of the window enable
    task set_en(input logic v);
        sram_en_val = v;
        sram_en_wr = 1'b1;
        @(posedge ref_clk);
        #1;
        sram_en_wr = 1'b0;
    endtask : set_en

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task t_reset;
        `CHK("enable", 1'b0, onchip_sram_enable)
        `CHK("busy", 1'b0, busy)
        `CHK("strobes", 2'b11, ({rd_n, wr_n}))
    endtask : t_reset

    // window off: both window ends and two addresses above it, low and high, go out on the bus
    task t_disabled;
        logic [15:0] tbl [4] = '{16'h0000, 16'h03ff, 16'h0400, 16'hffff};
        foreach (tbl[j]) begin
            access(MDR_KIND_MOVE, 1'b1, tbl[j], pat(tbl[j]));
            `CHK("write strobe clocks", 4, n_wr)
            `CHK("latched address", tbl[j], seen_a)
            `CHK("address drive", 0, n_bad)
            access(MDR_KIND_MOVE, 1'b0, tbl[j], 8'h00);
            `CHK("read data", pat(tbl[j]), got)
            `CHK("read length", 9, cyc)
            `CHK("no write on read", 0, n_wr)
            `CHK("high address drive", 0, n_bad)
        end
    endtask : t_disabled

    // window on: 0000h-03ffh internal and silent on the bus, 0400h external
    task t_window;
        set_en(1'b1);
        `CHK("enable set", 1'b1, onchip_sram_enable)
        access(MDR_KIND_MOVE, 1'b1, 16'h03ff, 8'hc3);
        `CHK("window write bus", 0, n_ale + n_wr + n_rd)
        access(MDR_KIND_MOVE, 1'b1, 16'h0000, 8'h3c);
        access(MDR_KIND_MOVE, 1'b0, 16'h03ff, 8'h00);
        `CHK("window top data", 8'hc3, got)
        `CHK("window length", 2, cyc)
        access(MDR_KIND_MOVE, 1'b0, 16'h0000, 8'h00);
        `CHK("window base data", 8'h3c, got)
        `CHK("window read bus", 0, n_ale + n_rd)
        `CHK("outside untouched", pat(16'h03ff), u_ext.mem[16'h03ff])
        access(MDR_KIND_MOVE, 1'b0, 16'h0400, 8'h00);
        `CHK("above window", pat(16'h0400), got)
        `CHK("above window strobe", 4, n_rd)
    endtask : t_window

    // a fetch never sees the window even inside its range
    task t_fetch;
        // a long move setting must not stretch a fetch
        stretch = 4'h5;
        access(MDR_KIND_FETCH, 1'b0, 16'h03ff, 8'h00);
        `CHK("fetch data", pat(16'h03ff), got)
        `CHK("fetch uses program strobe", 1'b1, (n_ps > 0 && n_rd == 0))
        `CHK("fetch length", 9, cyc)
        stretch = 4'h2;
    endtask : t_fetch

    // every move length from two to nine machine cycles
    task t_stretch;
        for (int s = 2; s <= 9; s++) begin
            stretch = 4'(s);
            access(MDR_KIND_MOVE, 1'b0, 16'h0400, 8'h00);
            `CHK("move length", s * 4 + 1, cyc)
            `CHK("strobe clocks", s * 4 - 4, n_rd)
        end
        // settings outside two to nine are clamped to the nearest end
        stretch = 4'h0;
        access(MDR_KIND_MOVE, 1'b0, 16'h0400, 8'h00);
        `CHK("clamped short length", 9, cyc)
        stretch = 4'hf;
        access(MDR_KIND_MOVE, 1'b0, 16'h0400, 8'h00);
        `CHK("clamped long length", 37, cyc)
        stretch = 4'h2;
    endtask : t_stretch

    // scratchpad apart from the window; registers only by direct address
    task t_scratch;
        access(MDR_KIND_INDIRECT, 1'b1, 16'h0085, 8'h11);
        access(MDR_KIND_DIRECT, 1'b1, 16'h0005, 8'h22);
        access(MDR_KIND_MOVE, 1'b1, 16'h0005, 8'h33);
        access(MDR_KIND_INDIRECT, 1'b0, 16'h0005, 8'h00);
        `CHK("pad low", 8'h22, got)
        access(MDR_KIND_MOVE, 1'b0, 16'h0005, 8'h00);
        `CHK("window apart", 8'h33, got)
        access(MDR_KIND_INDIRECT, 1'b0, 16'h0085, 8'h00);
        `CHK("pad high indirect", 8'h11, got)
        `CHK("pad high hit", 1'b0, hit)
        access(MDR_KIND_DIRECT, 1'b0, 16'h0085, 8'h00);
        `CHK("register hit", 1'b1, hit)
    endtask : t_scratch

    // wait function takes the pin as input and stretches the strobe
    task t_wait;
        wait_gpio_oe = 1'b1;
        wait_gpio_out = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        `CHK("pin as output", 2'b10, ({pin_oe, pin_out}))
        wait_enable = 1'b1;
        wait_hold = 8'h06;
        repeat (2) @(posedge ref_clk);
        #1;
        `CHK("pin input only", 1'b0, pin_oe)
        access(MDR_KIND_MOVE, 1'b0, 16'h0400, 8'h00);
        `CHK("waited read", pat(16'h0400), got)
        `CHK("strobe held", 1'b1, (cyc > 9))
        wait_hold = 8'h00;
        wait_enable = 1'b0;
        wait_gpio_oe = 1'b0;
    endtask : t_wait

    // reset in mid-access turns the window off again
    task t_mid_reset;
        req = '{1'b1, 1'b0, MDR_KIND_MOVE, 16'h0400, 8'h00};
        @(posedge ref_clk);
        #1;
        req.valid = 1'b0;
        repeat (3) @(posedge ref_clk);
        #1;
        nrst = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        `CHK("enable after reset", 1'b0, onchip_sram_enable)
        `CHK("idle after reset", 4'h3, ({busy, ale, rd_n, wr_n}))
        nrst = 1'b1;
        access(MDR_KIND_MOVE, 1'b0, 16'h03ff, 8'h00);
        `CHK("low range external", pat(16'h03ff), got)
    endtask : t_mid_reset

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (8) @(posedge ref_clk);
        #1;
        nrst = 1'b1;
        t_reset();
        t_disabled();
        t_window();
        t_fetch();
        t_stretch();
        t_scratch();
        t_wait();
        t_mid_reset();
        end_of_test();
    end
endmodule : mdr_router_test
